// ==== rtl/pcg_pkg.sv ====
// Purpose: Shared constants for the peripheral clock gating block
// Assumes: One system clock, one instruction cycle per cy_en pulse
// Notes:   Reset values of the gate bits live here
package pcg_pkg;
  // ----------------------------------------
  // Sizes and reset values
  // ----------------------------------------
  localparam int          NUM_MODULES    = 8;
  localparam int          GATE_DELAY_CY  = 1;
  localparam logic [7:0]  IMPL_DEFAULT   = 8'hFF;
  localparam logic [7:0]  GATE_RESET     = 8'h00;
  localparam int          CY_DIV_DEFAULT = 2;
endpackage : pcg_pkg

// ==== rtl/pcg_gate.sv ====
// Purpose: Per-module disable bits that stop module clocks and freeze register access
// Assumes: Software bits arrive on the system clock; module clocks are enables
// Notes:   Gates act one instruction cycle after the bit changes
//
// Contract
// - A set disable bit stops every clock feeding that module.
// - While disabled, writes to the module registers are blocked at once; reads are flagged invalid from the next clock.
// - A module runs only when its bit is clear and it is implemented.
// - Implemented modules leave reset with their disable bit clear.
// - Setting a bit disables the module one instruction cycle later.
// - Clearing a bit re-enables the module one instruction cycle later if its own control asks to run.
`timescale 1ns/1ps
module pcg_gate #(
  parameter int                NUM_MODULES = pcg_pkg::NUM_MODULES,
  parameter logic [NUM_MODULES-1:0] IMPL   = pcg_pkg::IMPL_DEFAULT[NUM_MODULES-1:0],
  parameter int                CY_DIV      = pcg_pkg::CY_DIV_DEFAULT
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   cy_en,
  input  wire logic                   gate_we,
  input  wire logic [NUM_MODULES-1:0] gate_wdata,
  input  wire logic [NUM_MODULES-1:0] mod_ctrl_on,
  input  wire logic [NUM_MODULES-1:0] mod_reg_we,
  output logic      [NUM_MODULES-1:0] module_clock_gate_bits,
  output logic      [NUM_MODULES-1:0] mod_clk_en,
  output logic      [NUM_MODULES-1:0] mod_reg_we_ok,
  output logic      [NUM_MODULES-1:0] mod_rd_valid,
  output logic      [NUM_MODULES-1:0] mod_active
);

  // ----------------------------------------
  // Software disable bits
  // ----------------------------------------
  logic [NUM_MODULES-1:0] gate_bits;
  logic [NUM_MODULES-1:0] gate_applied;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_bits <= pcg_pkg::GATE_RESET[NUM_MODULES-1:0];
    end else if (gate_we) begin
      // Absent modules get their bit forced set on each write; reset still clears it
      gate_bits <= gate_wdata | ~IMPL;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_applied <= pcg_pkg::GATE_RESET[NUM_MODULES-1:0];
    end else if (cy_en) begin
      gate_applied <= gate_bits;
    end
  end

  // ----------------------------------------
  // Gated enables
  // ----------------------------------------
  logic [NUM_MODULES-1:0] next_clk_en;

  assign mod_active = ~gate_applied & IMPL;

  always_comb begin
    next_clk_en = mod_active & mod_ctrl_on;
  end

  // registered enable
  // Enable changes only at a system clock edge, so a module never sees a cut pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mod_clk_en <= '0;
    end else begin
      mod_clk_en <= next_clk_en;
    end
  end

  assign mod_reg_we_ok = mod_reg_we & mod_active;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mod_rd_valid <= '0;
    end else begin
      mod_rd_valid <= mod_active;
    end
  end

  assign module_clock_gate_bits = gate_bits;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_MODULES; g++) begin : g_chk
      a_clk_stops: assert property (@(posedge clk) disable iff (rst)
        gate_applied[g] |=> !mod_clk_en[g])
        else $error("module clock runs while disabled");
      a_write_block: assert property (@(posedge clk) disable iff (rst)
        !mod_active[g] |-> !mod_reg_we_ok[g])
        else $error("write passed to disabled module");
      a_absent_off: assert property (@(posedge clk) disable iff (rst)
        !IMPL[g] |-> !mod_active[g] && !mod_rd_valid[g])
        else $error("absent module active");
      a_set_delay: assert property (@(posedge clk) disable iff (rst)
        cy_en && gate_bits[g] |=> !mod_active[g])
        else $error("disable not applied after cycle");
      a_clear_delay: assert property (@(posedge clk) disable iff (rst)
        cy_en && !gate_bits[g] && IMPL[g] ##1 mod_ctrl_on[g] |=> mod_clk_en[g])
        else $error("enable not restored");
      a_hold_between: assert property (@(posedge clk) disable iff (rst)
        !cy_en |=> $stable(gate_applied[g]))
        else $error("gate changed off instruction edge");
      a_no_glitch: assert property (@(posedge clk) disable iff (rst)
        $rose(mod_clk_en[g]) |-> $past(mod_active[g] && mod_ctrl_on[g]))
        else $error("clock enable without cause");
      a_write_pass: assert property (@(posedge clk) disable iff (rst)
        mod_active[g] && mod_reg_we[g] |-> mod_reg_we_ok[g])
        else $error("write lost on enabled module");
      a_read_valid: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> mod_rd_valid[g] == $past(mod_active[g]))
        else $error("read valid out of step with module state");
      a_absent_set: assert property (@(posedge clk) disable iff (rst)
        gate_we && !IMPL[g] |=> module_clock_gate_bits[g])
        else $error("absent module bit not forced");
      a_reset_on: assert property (@(posedge clk)
        $fell(rst) && IMPL[g] |-> !gate_bits[g] && !gate_applied[g])
        else $error("module not enabled after reset");
    end
  endgenerate

endmodule : pcg_gate

// ==== verification/pcg_gate_tb.sv ====
// Purpose: Self-checking bench for pcg_gate
// Assumes: All modules implemented, own control on until the first write, then random per write
// Notes:   Output snapshots queued by driver, checked at negedge
`timescale 1ns/1ps
module pcg_gate_tb;
  logic        clk = 0, rst = 1, cy_en = 0, gate_we = 0;
  logic [7:0]  wd = 8'h00, on = 8'hFF, we = 8'h00, gb, ce, wok, rv, act, r, p = 8'h00;
  logic [39:0] q[$];
  int          miscompares = 0, total_checks = 0, cyc = 0, seed = 32'h05eea395;
  always #2.5 clk = ~clk;
  pcg_gate pcg_gate_inst (.clk(clk), .rst(rst), .cy_en(cy_en), .gate_we(gate_we), .gate_wdata(wd),
    .mod_ctrl_on(on), .mod_reg_we(we), .module_clock_gate_bits(gb), .mod_clk_en(ce),
    .mod_reg_we_ok(wok), .mod_rd_valid(rv), .mod_active(act));
  task automatic chk(input logic [39:0] e, input logic [39:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t exp %h got %h", $time, e, g);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  // Gate bits, active, write pass, clock enable, read valid
  task automatic note(input logic [7:0] g, input logic [7:0] a, input logic [7:0] c);
    // Own control masks the clock enable, never the read-valid flag
    q.push_back({g, a, we & a, c & on, c});
  endtask : note
  always @(negedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      miscompares++;
      end_sim();
    end
    if (q.size() > 0) chk(q.pop_front(), {gb, act, wok, ce, rv});
  end
  initial begin
    #1;
    note(8'h00, 8'hFF, 8'h00);
    repeat (3) @(posedge clk);
    #1 rst = 0;
    cy_en = 1;
    @(posedge clk);
    #1 cy_en = 0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 40; i++) begin
      r = 8'($random(seed));
      @(posedge clk);
      #1 gate_we = 1;
      wd = r;
      we = 8'($random(seed));
      on = 8'($random(seed));
      @(posedge clk);
      #1 gate_we = 0;
      note(r, ~p, ~p);
      @(posedge clk);
      #1 cy_en = 1;
      @(posedge clk);
      #1 cy_en = 0;
      note(r, ~r, ~p);
      @(posedge clk);
      #1 note(r, ~r, ~r);
      p = r;
    end
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule : pcg_gate_tb
